// ---- shared/rstc_defs.vh ----
// Constants for the reset and stop-recovery block.
`ifndef RSTC_DEFS_VH
`define RSTC_DEFS_VH

`define RSTC_OFS_WDCTL      5'h00
`define RSTC_OFS_OPTION     5'h04
`define RSTC_OFS_WAKE_EN    5'h08
`define RSTC_OFS_PORT_IN    5'h0c
`define RSTC_OFS_STATE      5'h10

`define RSTC_WDCTL_POR      7
`define RSTC_WDCTL_STOP     6
`define RSTC_WDCTL_WDT      5

`define RSTC_OPT_WATCHDOG_RESET_SELECT_OPTION    0
`define RSTC_OPT_BO_KEEP    1
`define RSTC_OPT_RESET      2'h3
`define RSTC_WAKE_EN_RESET  1'b0

`define RSTC_CLK_PERIOD_PS  4000
`define RSTC_SYS_RESET_NS   1000
`define RSTC_STOP_REC_NS    1000
`define RSTC_WAKE_FILTER_NS 10

`endif

// ---- design/rstc_wake_detect.v ----
// Per-pin synchroniser, glitch filter and stop wake-up transition detector.
`timescale 1ns/10ps
`default_nettype none
`include "rstc_defs.vh"

module rstc_wake_detect #(
    parameter PINS   = 8,
    parameter FILTER = 3
) (
    input  wire            sys_clk,
    input  wire            srst,
    input  wire            clk_en,
    input  wire [PINS-1:0] gpio_pin,
    input  wire [PINS-1:0] wake_en,
    input  wire            track,
    output wire [PINS-1:0] pin_sync,
    output reg             wake_hit
);
    localparam [31:0] FILT_FULL = FILTER - 1;
    localparam [1:0]  FILT_LAST = FILT_FULL[1:0];

    wire [PINS-1:0] hit;

    genvar i;
    generate
        for (i = 0; i < PINS; i = i + 1) begin : g_pin
            reg       meta;
            reg       stable;
            reg       ref_level;
            reg [1:0] run_cnt;
            wire      differ = (stable != ref_level);
            always @(posedge sys_clk) begin
                if (srst) begin
                    meta      <= 1'b0;
                    stable    <= 1'b0;
                    ref_level <= 1'b0;
                    run_cnt   <= 2'h0;
                end else if (clk_en) begin
                    meta   <= gpio_pin[i];
                    stable <= meta;
                    // While running the reference follows the pin, so entering
                    // stop compares against the last level seen before it.
                    if (track) begin
                        ref_level <= stable;
                        run_cnt   <= 2'h0;
                    end else if (differ && wake_en[i]) begin
                        if (run_cnt != FILT_LAST)
                            run_cnt <= run_cnt + 2'h1;
                    end else begin
                        run_cnt <= 2'h0;
                    end
                end
            end
            // Either direction of change counts, and the hit is latched by
            // the caller, so a pulse that returns is still a wake-up.
            assign hit[i]      = differ && wake_en[i] && !track &&
                                 (run_cnt == FILT_LAST);
            assign pin_sync[i] = stable;
        end
    endgenerate

    always @(posedge sys_clk) begin
        if (srst)
            wake_hit <= 1'b0;
        else if (clk_en)
            wake_hit <= |hit;
    end
endmodule
`default_nettype wire

// ---- design/rstc_top.v ----
// Reset, brownout hold, watchdog reset and stop-recovery controller.
`timescale 1ns/10ps
`default_nettype none
`include "rstc_defs.vh"

module rstc_top #(
    parameter PINS             = 8,
    parameter SYS_RESET_CYCLES = (`RSTC_SYS_RESET_NS * 1000 +
                                  `RSTC_CLK_PERIOD_PS - 1) / `RSTC_CLK_PERIOD_PS,
    parameter STOP_REC_CYCLES  = (`RSTC_STOP_REC_NS * 1000 +
                                  `RSTC_CLK_PERIOD_PS - 1) / `RSTC_CLK_PERIOD_PS
) (
    input  wire            sys_clk,
    input  wire            srst,
    input  wire            clk_en,
    input  wire [4:0]      avs_address,
    input  wire            avs_read,
    input  wire            avs_write,
    input  wire [31:0]     avs_writedata,
    input  wire [3:0]      avs_byteenable,
    output reg  [31:0]     avs_readdata,
    output reg             avs_waitrequest,
    input  wire            supply_brownout_monitor,
    input  wire            wdt_timeout,
    input  wire            wdt_irq_mode,
    input  wire            cpu_irq_enable,
    input  wire            cpu_stop,
    input  wire [PINS-1:0] gpio_pin,
    output reg             sys_reset,
    output reg             brownout_mon_en,
    output reg             stop_exit,
    output reg             wdt_irq_req,
    output reg  [PINS-1:0] port_input_data_reg
);
    localparam FILTER_CYCLES = (`RSTC_WAKE_FILTER_NS * 1000 +
                                `RSTC_CLK_PERIOD_PS - 1) / `RSTC_CLK_PERIOD_PS;
    localparam [31:0] RST_FULL  = SYS_RESET_CYCLES - 1;
    localparam [31:0] STOP_FULL = STOP_REC_CYCLES - 1;
    localparam [15:0] RST_LAST  = RST_FULL[15:0];
    localparam [15:0] STOP_LAST = STOP_FULL[15:0];

    localparam [3:0] ST_HOLD = 4'h1;
    localparam [3:0] ST_RSEQ = 4'h2;
    localparam [3:0] ST_RUN  = 4'h4;
    localparam [3:0] ST_SREC = 4'h8;

    reg  [3:0]      state;
    reg  [3:0]      next_state;
    reg  [15:0]     cnt;
    reg             bo_meta;
    reg             bo_low;
    reg             por_pending;
    reg             irq_pending;
    reg             flag_por;
    reg             flag_stop;
    reg             flag_wdt;
    reg  [1:0]      option;
    reg  [PINS-1:0] wake_en;
    wire [PINS-1:0] pin_sync;
    wire            wake_hit;

    wire bus_take  = (avs_read || avs_write) && !avs_waitrequest;
    wire wr_take   = bus_take && avs_write && avs_byteenable[0];
    wire wr_wdctl  = wr_take && (avs_address == `RSTC_OFS_WDCTL);
    wire wr_option = wr_take && (avs_address == `RSTC_OFS_OPTION);
    wire wr_wake   = wr_take && (avs_address == `RSTC_OFS_WAKE_EN);

    // The core still shows stop in the cycle of the exit pulse; that cycle
    // must not count as stop, or a pin still away from its old level would
    // start a second recovery at once.
    wire in_stop     = cpu_stop && (state == ST_RUN) && !stop_exit;
    // With the keep option clear the monitor is off in stop, so its report
    // is ignored there rather than trusted from a powered-down comparator.
    wire bo_active   = !in_stop || option[`RSTC_OPT_BO_KEEP];
    wire bo_trip     = bo_low && bo_active;
    wire cnt_rst_end = (cnt == RST_LAST);
    wire cnt_rec_end = (cnt == STOP_LAST);
    wire wdt_reset   = wdt_timeout && !in_stop && (state == ST_RUN) &&
                       option[`RSTC_OPT_WATCHDOG_RESET_SELECT_OPTION];
    wire wdt_wake    = wdt_timeout && in_stop;
    wire pin_wake    = wake_hit && in_stop;
    wire track       = (state == ST_RUN) && !cpu_stop;

    rstc_wake_detect #(
        .PINS   (PINS),
        .FILTER (FILTER_CYCLES)
    ) u_wake (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .gpio_pin (gpio_pin),
        .wake_en  (wake_en),
        .track    (track),
        .pin_sync (pin_sync),
        .wake_hit (wake_hit)
    );

    always @* begin
        next_state = state;
        case (state)
            ST_HOLD: begin
                if (!bo_low)
                    next_state = ST_RSEQ;
            end
            ST_RSEQ: begin
                if (bo_low)
                    next_state = ST_HOLD;
                else if (cnt_rst_end)
                    next_state = ST_RUN;
            end
            ST_RUN: begin
                if (bo_trip)
                    next_state = ST_HOLD;
                else if (wdt_reset)
                    next_state = ST_RSEQ;
                else if (wdt_wake || pin_wake)
                    next_state = ST_SREC;
            end
            ST_SREC: begin
                if (bo_trip)
                    next_state = ST_HOLD;
                else if (cnt_rec_end)
                    next_state = ST_RUN;
            end
            default: next_state = ST_HOLD;
        endcase
    end

    // Brownout report arrives from an analog comparator, hence two stages.
    always @(posedge sys_clk) begin
        if (srst) begin
            bo_meta <= 1'b0;
            bo_low  <= 1'b0;
        end else if (clk_en) begin
            bo_meta <= supply_brownout_monitor;
            bo_low  <= bo_meta;
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            state       <= ST_RSEQ;
            cnt         <= 16'h0000;
            por_pending <= 1'b1;
            irq_pending <= 1'b0;
            sys_reset   <= 1'b1;
            stop_exit   <= 1'b0;
            wdt_irq_req <= 1'b0;
        end else if (clk_en) begin
            state       <= next_state;
            stop_exit   <= 1'b0;
            wdt_irq_req <= 1'b0;
            if (next_state != state)
                cnt <= 16'h0000;
            else if (state == ST_RSEQ || state == ST_SREC)
                cnt <= cnt + 16'h0001;
            sys_reset <= (next_state == ST_HOLD) || (next_state == ST_RSEQ);
            if (state == ST_HOLD)
                por_pending <= 1'b1;
            else if (state == ST_RSEQ && next_state == ST_RUN)
                por_pending <= 1'b0;
            if (state == ST_RUN && wdt_wake)
                irq_pending <= wdt_irq_mode && cpu_irq_enable;
            if (state == ST_SREC && next_state == ST_RUN) begin
                stop_exit   <= 1'b1;
                wdt_irq_req <= irq_pending;
                irq_pending <= 1'b0;
            end
        end
    end

    // Cause flags: hardware setting wins over a software write-1 clear.
    always @(posedge sys_clk) begin
        if (srst) begin
            flag_por  <= 1'b0;
            flag_stop <= 1'b0;
            flag_wdt  <= 1'b0;
        end else if (clk_en) begin
            if (state == ST_RSEQ && next_state == ST_RUN && por_pending)
                flag_por <= 1'b1;
            else if (wr_wdctl && avs_writedata[`RSTC_WDCTL_POR])
                flag_por <= 1'b0;
            if (state == ST_RUN && (wdt_wake || pin_wake) && !bo_trip)
                flag_stop <= 1'b1;
            else if (wr_wdctl && avs_writedata[`RSTC_WDCTL_STOP])
                flag_stop <= 1'b0;
            if ((wdt_reset || wdt_wake) && !bo_trip)
                flag_wdt <= 1'b1;
            else if (wr_wdctl && avs_writedata[`RSTC_WDCTL_WDT])
                flag_wdt <= 1'b0;
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            option  <= `RSTC_OPT_RESET;
            wake_en <= {PINS{`RSTC_WAKE_EN_RESET}};
        end else if (clk_en) begin
            if (wr_option)
                option <= avs_writedata[1:0];
            if (wr_wake)
                wake_en <= avs_writedata[PINS-1:0];
        end
    end

    // Input data freezes from stop entry until recovery has run its full
    // delay, then takes the level present at that moment, whether or not it lasted the delay.
    always @(posedge sys_clk) begin
        if (srst) begin
            port_input_data_reg <= {PINS{1'b0}};
            brownout_mon_en     <= 1'b1;
        end else if (clk_en) begin
            if (track)
                port_input_data_reg <= pin_sync;
            else if (state == ST_SREC && next_state == ST_RUN)
                port_input_data_reg <= pin_sync;
            brownout_mon_en <= bo_active;
        end
    end

    // Each access waits one cycle, then completes with waitrequest low.
    always @(posedge sys_clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else if (clk_en) begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            avs_readdata    <= 32'h00000000;
            if (avs_read && avs_waitrequest) begin
                case (avs_address)
                    `RSTC_OFS_WDCTL: begin
                        avs_readdata[`RSTC_WDCTL_POR]  <= flag_por;
                        avs_readdata[`RSTC_WDCTL_STOP] <= flag_stop;
                        avs_readdata[`RSTC_WDCTL_WDT]  <= flag_wdt;
                    end
                    `RSTC_OFS_OPTION:  avs_readdata[1:0] <= option;
                    `RSTC_OFS_WAKE_EN: avs_readdata[PINS-1:0] <= wake_en;
                    `RSTC_OFS_PORT_IN: avs_readdata[PINS-1:0] <= port_input_data_reg;
                    `RSTC_OFS_STATE:   avs_readdata[3:0] <= state;
                    default:           avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/rstc_chk.sv ----
// Concurrent checks on the ports of the reset and stop-recovery block.
`timescale 1ns/10ps
`default_nettype none
module rstc_chk #(
    parameter int PINS             = 8,
    parameter int SYS_RESET_CYCLES = 8,
    parameter int STOP_REC_CYCLES  = 8
) (
    input wire logic            sys_clk,
    input wire logic            srst,
    input wire logic [4:0]      avs_address,
    input wire logic            avs_read,
    input wire logic            avs_write,
    input wire logic [31:0]     avs_writedata,
    input wire logic [3:0]      avs_byteenable,
    input wire logic            avs_waitrequest,
    input wire logic            supply_brownout_monitor,
    input wire logic            wdt_timeout,
    input wire logic            cpu_irq_enable,
    input wire logic            cpu_stop,
    input wire logic            sys_reset,
    input wire logic            brownout_mon_en,
    input wire logic            stop_exit,
    input wire logic            wdt_irq_req,
    input wire logic [PINS-1:0] port_input_data_reg
);
    localparam int REC_D = STOP_REC_CYCLES + 1;
    logic        opt_res;
    logic        opt_keep;
    logic        in_rec;
    logic [15:0] hi_cnt;
    wire logic   opt_wr = avs_write && !avs_waitrequest && avs_address == 5'h04
                          && avs_byteenable[0];
    wire logic   dog_stop = wdt_timeout && cpu_stop && !sys_reset && !in_rec;
    // The option bits are mirrored from bus writes because they never reach a port.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hi_cnt   <= 16'h0;
            opt_res  <= 1'b1;
            opt_keep <= 1'b1;
            in_rec   <= 1'b0;
        end else begin
            hi_cnt <= sys_reset ? hi_cnt + 16'h1 : 16'h0;
            if (opt_wr) begin
                opt_res  <= avs_writedata[0];
                opt_keep <= avs_writedata[1];
            end
            in_rec <= dog_stop || (in_rec && !stop_exit);
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence bo_low;
        (supply_brownout_monitor && brownout_mon_en) [*4];
    endsequence
    sequence rec_end;
        ##[REC_D:REC_D] stop_exit;
    endsequence
    bo_hold_a: assert property (bo_low |-> sys_reset)
        else $error("brownout did not hold reset");
    rec_seq_a: assert property ($fell(sys_reset) |-> hi_cnt >= SYS_RESET_CYCLES)
        else $error("reset sequence too short");
    bo_stop_a: assert property ((cpu_stop && !opt_keep && !in_rec) [*3] |-> !brownout_mon_en)
        else $error("monitor left on in stop");
    bo_run_a: assert property ((!cpu_stop) [*3] |-> brownout_mon_en)
        else $error("monitor off outside stop");
    dog_reset_a: assert property (wdt_timeout && !cpu_stop && !sys_reset && opt_res |=> sys_reset)
        else $error("time-out gave no reset");
    stop_rec_a: assert property (dog_stop |=> !sys_reset)
        else $error("time-out in stop gave reset");
    rec_len_a: assert property (dog_stop |-> rec_end)
        else $error("recovery length wrong");
    irq_pair_a: assert property (wdt_irq_req |-> stop_exit && cpu_irq_enable)
        else $error("interrupt outside recovery end");
    port_hold_a: assert property ((cpu_stop && !stop_exit) [*2] |-> $stable(port_input_data_reg))
        else $error("port data moved in stop");
    bus_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    bus_ans_a: assert property ($rose(avs_read) || $rose(avs_write) |=> !avs_waitrequest)
        else $error("bus answer late");
endmodule
bind rstc_top rstc_chk #(
    .PINS(PINS), .SYS_RESET_CYCLES(SYS_RESET_CYCLES), .STOP_REC_CYCLES(STOP_REC_CYCLES)
) i_chk (.*);
`default_nettype wire

// ---- tb/rstc_cpu_model.sv ----
// CPU stand-in that enters stop on request and leaves it after recovery.
`timescale 1ns/10ps
`default_nettype none
module rstc_cpu_model (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic stop_req,
    input  wire logic stop_exit,
    output var  logic cpu_stop
);
    // The core cannot leave stop by itself; only the end of recovery wakes it.
    always @(posedge sys_clk) begin
        if (srst || stop_exit)
            cpu_stop <= 1'b0;
        else if (stop_req)
            cpu_stop <= 1'b1;
    end
endmodule
`default_nettype wire

// ---- tb/reset_and_stop_recovery_tb_top.sv ----
// Self-checking bench for the reset and stop-recovery block.
`timescale 1ns/10ps
`default_nettype none
module reset_and_stop_recovery_tb_top;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        clk_en = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        supply_brownout_monitor = 1'b0;
    logic        wdt_timeout = 1'b0;
    logic        wdt_irq_mode = 1'b0;
    logic        cpu_irq_enable = 1'b0;
    logic        cpu_stop;
    logic        stop_req = 1'b0;
    logic [7:0]  gpio_pin = 8'h00;
    logic        sys_reset;
    logic        brownout_mon_en;
    logic        stop_exit;
    logic        wdt_irq_req;
    logic [7:0]  port_input_data_reg;
    logic [31:0] dq;
    logic        irq_seen;
    int          n_tests = 0;
    int          bad_count = 0;
    rstc_top #(.SYS_RESET_CYCLES(8), .STOP_REC_CYCLES(8)) i_dut (.*);
    rstc_cpu_model i_cpu (.*);
    always #2 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        for (int i = 0; i < 9; i++) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (avs_waitrequest !== 1'b0) begin
            bad_count++;
            $display("[ERR] bus exp 0 seen %b", avs_waitrequest);
        end
        dq = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, dq, e);
    endtask
    task automatic kick;
        @(posedge sys_clk);
        wdt_timeout <= 1'b1;
        @(posedge sys_clk);
        wdt_timeout <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic stop;
        @(posedge sys_clk);
        stop_req <= 1'b1;
        @(posedge sys_clk);
        stop_req <= 1'b0;
    endtask
    // Waits for run when rs is set, else for the end of recovery.
    task automatic till(input bit rs);
        for (int i = 0; i < 64; i++) begin
            if (rs ? sys_reset === 1'b0 : stop_exit === 1'b1) break;
            @(posedge sys_clk);
        end
        irq_seen = wdt_irq_req;
    endtask
    task automatic t_por;
        till(1'b1);
        chk("run", sys_reset, 32'h0);
        rdc("wdctl", 5'h00, 32'h80);
        rdc("option", 5'h04, 32'h03);
        rdc("wake_en", 5'h08, 32'h00);
        bus(1'b1, 5'h00, 32'he0);
        rdc("wdctl", 5'h00, 32'h00);
        $display("por done");
    endtask
    task automatic t_wdt;
        kick;
        chk("dog", sys_reset, 32'h1);
        till(1'b1);
        rdc("wdctl", 5'h00, 32'h20);
        bus(1'b1, 5'h00, 32'he0);
        bus(1'b1, 5'h04, 32'h02);
        kick;
        repeat (4) @(posedge sys_clk);
        chk("no_dog", sys_reset, 32'h0);
        rdc("wdctl", 5'h00, 32'h00);
        bus(1'b1, 5'h04, 32'h03);
        $display("watchdog done");
    endtask
    task automatic t_bo;
        supply_brownout_monitor <= 1'b1;
        repeat (12) @(posedge sys_clk);
        chk("hold", sys_reset, 32'h1);
        supply_brownout_monitor <= 1'b0;
        repeat (6) @(posedge sys_clk);
        chk("seq", sys_reset, 32'h1);
        till(1'b1);
        rdc("wdctl", 5'h00, 32'h80);
        bus(1'b1, 5'h00, 32'he0);
        $display("brownout done");
    endtask
    task automatic t_swdt;
        bus(1'b1, 5'h04, 32'h01);
        wdt_irq_mode   <= 1'b1;
        cpu_irq_enable <= 1'b1;
        stop;
        repeat (4) @(posedge sys_clk);
        chk("mon_off", brownout_mon_en, 32'h0);
        kick;
        chk("no_reset", sys_reset, 32'h0);
        till(1'b0);
        chk("irq", irq_seen, 32'h1);
        rdc("wdctl", 5'h00, 32'h60);
        bus(1'b1, 5'h00, 32'he0);
        bus(1'b1, 5'h04, 32'h03);
        wdt_irq_mode <= 1'b0;
        $display("stop watchdog done");
    endtask
    task automatic t_pin;
        bus(1'b1, 5'h08, 32'h04);
        for (int r = 0; r < 2; r++) begin
            gpio_pin <= r ? 8'h04 : 8'h00;
            repeat (6) @(posedge sys_clk);
            chk("port", port_input_data_reg, r ? 32'h04 : 32'h00);
            stop;
            gpio_pin[3] <= 1'b1;
            repeat (8) @(posedge sys_clk);
            chk("frozen", port_input_data_reg, r ? 32'h04 : 32'h00);
            chk("asleep", cpu_stop, 32'h1);
            gpio_pin[2] <= !r;
            if (r == 0) begin
                repeat (6) @(posedge sys_clk);
                gpio_pin[2] <= 1'b0;
            end
            till(1'b0);
            chk("woke", stop_exit, 32'h1);
            chk("pin_irq", irq_seen, 32'h0);
            chk("port_end", port_input_data_reg, 32'h08);
            rdc("wdctl", 5'h00, 32'h40);
            bus(1'b1, 5'h00, 32'he0);
        end
        $display("pin wake done");
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        t_por;
        t_wdt;
        t_bo;
        t_swdt;
        t_pin;
        close_out;
    end
    initial begin
        #20000;
        bad_count++;
        close_out;
    end
endmodule
`default_nettype wire
